// ### rtl/eac_core.sv
// Added by the designer: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "eac_defs.svh"
module eac_core import eac_pkg::*; (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic instrLoad,
    input wire logic [0:35] instrWord,
    output logic instrReady,
    output logic [3:0] fastRegAddr,
    input wire logic [0:35] fastRegData,
    output logic indirectRequestFn,
    output logic memField02,
    output logic memoryWait,
    input wire logic memRespValid,
    input wire logic [0:35] memRespWord,
    output logic [0:35] arithReg,
    output logic [13:35] virtualAddrReg,
    output logic fetchDispatch,
    output logic blockTransferOp,
    output logic dpFloatAdd,
    output logic dpFloatSub,
    output logic doubleIntMultiply,
    output logic [3:0] destAccBase,
    output logic [2:0] destAccCount
);
    eac_reg_if regs();
    eac_state_t state, next_state;
    logic [0:35] instrReg, instructionBufferReg, next_instrReg, next_ibr, next_arith;
    logic [13:35] next_vaddr;
    logic [0:35] adderOut;
    logic indexed, next_indexed, enable, next_enable;
    logic [7:0] indCount, next_indCount;
    logic next_bxfer, next_fpAdd, next_fpSub, next_iMul;
    logic [3:0] next_accBase;
    logic [2:0] next_accCount;

    // Shared adder: the upper half of each operand is supplied by the caller.
    function automatic logic [0:35] eaAdd(input logic [0:35] a, input logic [0:35] b);
        eaAdd = a + b;
    endfunction : eaAdd

    function automatic logic [2:0] destCount(input logic [0:8] op);
        if (op == `EAC_OP_DIMUL) begin
            destCount = `EAC_DEST_QUAD;
        end else if (op >= `EAC_OP_DPADD && op <= `EAC_OP_DPF_LAST) begin
            destCount = `EAC_DEST_PAIR;
        end else if (op >= `EAC_OP_DINT_FIRST && op < `EAC_OP_DDIV) begin
            destCount = `EAC_DEST_PAIR;
        end else begin
            destCount = `EAC_DEST_NONE;
        end
    endfunction : destCount

    eac_axil_slave u_slave (
        .clk(clk),
        .rst_n(rst_n),
        .awaddr(awaddr),
        .awvalid(awvalid),
        .awready(awready),
        .wdata(wdata),
        .wstrb(wstrb),
        .wvalid(wvalid),
        .wready(wready),
        .bresp(bresp),
        .bvalid(bvalid),
        .bready(bready),
        .araddr(araddr),
        .arvalid(arvalid),
        .arready(arready),
        .rdata(rdata),
        .rresp(rresp),
        .rvalid(rvalid),
        .rready(rready),
        .regs(regs.slave)
    );

    assign instrReady = (state == EAC_IDLE) && enable;
    assign fastRegAddr = instructionBufferReg[`EAC_XSEL_HI:`EAC_XSEL_LO];
    assign indirectRequestFn = (state == EAC_REQ);
    // The request step carries bit 02 low; the following wait step raises it.
    assign memField02 = (state == EAC_WAIT);
    assign memoryWait = memField02 && !memRespValid;
    assign fetchDispatch = (state == EAC_DISPATCH);
    assign regs.wrOk = (regs.wrAddr == `EAC_OFS_CTRL) || (regs.wrAddr == `EAC_OFS_VSECT);

    always_comb begin
        regs.rdOk = 1'b1;
        case (regs.rdAddr)
            `EAC_OFS_CTRL: regs.rdData = {31'h0, enable};
            `EAC_OFS_STATUS: regs.rdData = {27'h0, indexed, !instrReady, state};
            `EAC_OFS_ARITH: regs.rdData = {14'h0, arithReg[`EAC_Y_HI:`EAC_Y_LO]};
            `EAC_OFS_VADDR: regs.rdData = {9'h0, virtualAddrReg};
            `EAC_OFS_VSECT: regs.rdData = {27'h0, virtualAddrReg[`EAC_SECT_HI:`EAC_SECT_LO]};
            `EAC_OFS_DEST: regs.rdData = {21'h0, blockTransferOp, dpFloatAdd, dpFloatSub,
                                          doubleIntMultiply, destAccCount, destAccBase};
            `EAC_OFS_INDCNT: regs.rdData = {24'h0, indCount};
            default: begin
                regs.rdData = 32'h0;
                regs.rdOk = 1'b0;
            end
        endcase
    end

    always_comb begin
        next_enable = enable;
        if (regs.wrEn && regs.wrAddr == `EAC_OFS_CTRL && regs.wrStrb[0]) begin
            next_enable = regs.wrData[0];
        end
    end

    always_comb begin
        next_state = state;
        next_instrReg = instrReg;
        next_ibr = instructionBufferReg;
        next_arith = arithReg;
        next_vaddr = virtualAddrReg;
        next_indexed = indexed;
        next_indCount = indCount;
        next_bxfer = blockTransferOp;
        next_fpAdd = dpFloatAdd;
        next_fpSub = dpFloatSub;
        next_iMul = doubleIntMultiply;
        next_accBase = destAccBase;
        next_accCount = destAccCount;
        adderOut = 36'h0;
        // Software may seed the section bits only while no address is in flight.
        if (regs.wrEn && regs.wrAddr == `EAC_OFS_VSECT && regs.wrStrb[0] && state == EAC_IDLE) begin
            next_vaddr[`EAC_SECT_HI:`EAC_SECT_LO] = regs.wrData[4:0];
        end
        case (state)
            EAC_IDLE: begin
                if (instrLoad && instrReady) begin
                    next_instrReg = instrWord;
                    next_ibr = instrWord;
                    next_indexed = 1'b0;
                    next_indCount = 8'h0;
                    next_bxfer = instrWord[`EAC_OP_HI:`EAC_OP_LO] == `EAC_OP_BXFER;
                    next_fpAdd = instrWord[`EAC_OP_HI:`EAC_OP_LO] == `EAC_OP_DPADD;
                    next_fpSub = instrWord[`EAC_OP_HI:`EAC_OP_LO] == `EAC_OP_DPSUB;
                    next_iMul = instrWord[`EAC_OP_HI:`EAC_OP_LO] == `EAC_OP_DIMUL;
                    next_accBase = instrWord[`EAC_AC_HI:`EAC_AC_LO];
                    next_accCount = destCount(instrWord[`EAC_OP_HI:`EAC_OP_LO]);
                    next_state = EAC_DECODE;
                end
            end
            EAC_DECODE: begin
                // The same field layout applies whatever the opcode is.
                if (instructionBufferReg[`EAC_XSEL_HI:`EAC_XSEL_LO] != 4'h0) begin
                    next_state = EAC_INDEX;
                end else if (instructionBufferReg[`EAC_IND_BIT]) begin
                    next_state = EAC_INDIRECT;
                end else begin
                    adderOut = eaAdd({18'h0, instructionBufferReg[`EAC_Y_HI:`EAC_Y_LO]}, 36'h0);
                    next_arith = {18'h0, adderOut[`EAC_Y_HI:`EAC_Y_LO]};
                    next_state = EAC_DISPATCH;
                end
            end
            EAC_INDEX: begin
                adderOut = eaAdd(instructionBufferReg, fastRegData);
                next_arith = {18'h0, adderOut[`EAC_Y_HI:`EAC_Y_LO]};
                next_vaddr[`EAC_Y_HI:`EAC_Y_LO] = adderOut[`EAC_Y_HI:`EAC_Y_LO];
                next_indexed = 1'b1;
                next_state = instructionBufferReg[`EAC_IND_BIT] ? EAC_INDIRECT : EAC_DISPATCH;
            end
            EAC_INDIRECT: begin
                if (indexed) begin
                    adderOut = eaAdd(arithReg, 36'h0);
                end else begin
                    adderOut = eaAdd({18'h0, instructionBufferReg[`EAC_Y_HI:`EAC_Y_LO]}, 36'h0);
                end
                next_vaddr[`EAC_Y_HI:`EAC_Y_LO] = adderOut[`EAC_Y_HI:`EAC_Y_LO];
                next_state = EAC_REQ;
            end
            EAC_REQ: begin
                next_indCount = indCount + 8'h01;
                next_state = EAC_WAIT;
            end
            EAC_WAIT: begin
                // The fetched indirect word replaces the buffer and decoding restarts.
                if (memRespValid) begin
                    next_ibr = memRespWord;
                    next_indexed = 1'b0;
                    next_state = EAC_DECODE;
                end
            end
            EAC_DISPATCH: begin
                next_state = EAC_IDLE;
            end
            default: begin
                next_state = EAC_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state <= EAC_IDLE;
            instrReg <= 36'h0;
            instructionBufferReg <= 36'h0;
            arithReg <= 36'h0;
            virtualAddrReg <= 23'h0;
            indexed <= 1'b0;
            indCount <= 8'h0;
            enable <= `EAC_CTRL_RESET;
            blockTransferOp <= 1'b0;
            dpFloatAdd <= 1'b0;
            dpFloatSub <= 1'b0;
            doubleIntMultiply <= 1'b0;
            destAccBase <= 4'h0;
            destAccCount <= 3'h0;
        end else begin
            state <= next_state;
            instrReg <= next_instrReg;
            instructionBufferReg <= next_ibr;
            arithReg <= next_arith;
            virtualAddrReg <= next_vaddr;
            indexed <= next_indexed;
            indCount <= next_indCount;
            enable <= next_enable;
            blockTransferOp <= next_bxfer;
            dpFloatAdd <= next_fpAdd;
            dpFloatSub <= next_fpSub;
            doubleIntMultiply <= next_iMul;
            destAccBase <= next_accBase;
            destAccCount <= next_accCount;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    a_load_both_regs: assert property (
        (state == EAC_IDLE && instrLoad && instrReady) |=> state == EAC_DECODE
            && instrReg == $past(instrWord) && instructionBufferReg == $past(instrWord))
        else $error("decode began without both instruction registers loaded");
    a_index_select: assert property (
        (state == EAC_DECODE && instructionBufferReg[14:17] != 4'h0) |=> state == EAC_INDEX)
        else $error("nonzero index selector did not start indexing");
    a_index_sum: assert property (
        state == EAC_INDEX |=> arithReg[18:35] ==
            18'($past(instructionBufferReg[18:35]) + $past(fastRegData[18:35])))
        else $error("indexed sum is wrong");
    a_arith_upper: assert property (
        state == EAC_INDEX |=> arithReg[0:17] == 18'h0 && virtualAddrReg[18:35] == arithReg[18:35])
        else $error("arithmetic upper half not cleared after indexing");
    a_section_kept: assert property (
        state inside {EAC_INDEX, EAC_INDIRECT} |=> $stable(virtualAddrReg[13:17]))
        else $error("section bits of virtual address changed");
    a_indirect_taken: assert property (
        (state == EAC_INDEX && instructionBufferReg[13]) |=> state == EAC_INDIRECT ##1 state == EAC_REQ)
        else $error("indirect bit ignored after indexing");
    a_indirect_plain: assert property (
        (state == EAC_INDIRECT && !indexed) |=>
            virtualAddrReg[18:35] == $past(instructionBufferReg[18:35]))
        else $error("unindexed indirect address wrong");
    a_indirect_indexed: assert property (
        (state == EAC_INDIRECT && indexed) |=> virtualAddrReg[18:35] == $past(arithReg[18:35]))
        else $error("indexed indirect address wrong");
    a_wait_follows: assert property (
        indirectRequestFn |-> !memField02 ##1 (memField02 && memoryWait == !memRespValid))
        else $error("memory wait did not follow the indirect request");
    a_dest_decode: assert property (
        fetchDispatch |-> (doubleIntMultiply ? destAccCount == 3'h4 : 1'b1)
            && ((dpFloatAdd || dpFloatSub) ? destAccCount == 3'h2 : 1'b1)
            && (blockTransferOp == (instrReg[0:8] == 9'h0A9)))
        else $error("destination facts wrong at dispatch");
    a_direct_ea: assert property (
        (state == EAC_DECODE && instructionBufferReg[13:17] == 5'h00) |=>
            arithReg == {18'h0, $past(instructionBufferReg[18:35])} && fetchDispatch)
        else $error("direct effective address not formed");
    a_seq_order: assert property (
        state == EAC_REQ |-> $past(state) == EAC_INDIRECT ##1 state == EAC_WAIT)
        else $error("indirect request out of order");

    c_index_indirect: cover property (state == EAC_INDEX ##1 state == EAC_INDIRECT);
    c_indirect_chain: cover property (state == EAC_WAIT && memRespValid ##1 state == EAC_DECODE);
    c_direct: cover property (state == EAC_DECODE ##1 fetchDispatch);
    c_reg_write: cover property (regs.wrEn && regs.wrOk);
endmodule : eac_core
`default_nettype wire

// ### rtl/eac_defs.svh
`ifndef EAC_DEFS_SVH
`define EAC_DEFS_SVH
`define EAC_OFS_CTRL 8'h00
`define EAC_OFS_STATUS 8'h04
`define EAC_OFS_ARITH 8'h08
`define EAC_OFS_VADDR 8'h0C
`define EAC_OFS_VSECT 8'h10
`define EAC_OFS_DEST 8'h14
`define EAC_OFS_INDCNT 8'h18
`define EAC_CTRL_RESET 1'b1
`define EAC_IND_BIT 13
`define EAC_XSEL_HI 14
`define EAC_XSEL_LO 17
`define EAC_SECT_HI 13
`define EAC_SECT_LO 17
`define EAC_Y_HI 18
`define EAC_Y_LO 35
`define EAC_OP_HI 0
`define EAC_OP_LO 8
`define EAC_AC_HI 9
`define EAC_AC_LO 12
`define EAC_OP_BXFER 9'h0A9
`define EAC_OP_DPADD 9'h048
`define EAC_OP_DPSUB 9'h049
`define EAC_OP_DPF_LAST 9'h04B
`define EAC_OP_DINT_FIRST 9'h04C
`define EAC_OP_DIMUL 9'h04E
`define EAC_OP_DDIV 9'h04F
`define EAC_DEST_NONE 3'h0
`define EAC_DEST_PAIR 3'h2
`define EAC_DEST_QUAD 3'h4
`define EAC_RESP_OKAY 2'h0
`define EAC_RESP_SLVERR 2'h2
`endif

// ### rtl/eac_pkg.sv
package eac_pkg;
    typedef enum logic [2:0] {
        EAC_IDLE = 3'h0,
        EAC_DECODE = 3'h1,
        EAC_INDEX = 3'h3,
        EAC_INDIRECT = 3'h2,
        EAC_REQ = 3'h6,
        EAC_WAIT = 3'h7,
        EAC_DISPATCH = 3'h5
    } eac_state_t;
endpackage : eac_pkg

// ### rtl/eac_reg_if.sv
`timescale 1ns/1ps
`default_nettype none
interface eac_reg_if;
    logic wrEn;
    logic [7:0] wrAddr;
    logic [31:0] wrData;
    logic [3:0] wrStrb;
    logic wrOk;
    logic [7:0] rdAddr;
    logic [31:0] rdData;
    logic rdOk;
    modport slave(output wrEn, wrAddr, wrData, wrStrb, rdAddr, input wrOk, rdData, rdOk);
    modport core(input wrEn, wrAddr, wrData, wrStrb, rdAddr, output wrOk, rdData, rdOk);
endinterface : eac_reg_if
`default_nettype wire

// ### rtl/eac_axil_slave.sv
`timescale 1ns/1ps
`default_nettype none
`include "eac_defs.svh"
module eac_axil_slave import eac_pkg::*; (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    eac_reg_if.slave regs
);
    logic awHeld, wHeld, doWrite;
    logic [7:0] awAddrQ;
    logic [31:0] wDataQ;
    logic [3:0] wStrbQ;
    logic next_awHeld, next_wHeld, next_bvalid, next_rvalid;
    logic [7:0] next_awAddrQ;
    logic [31:0] next_wDataQ, next_rdata;
    logic [3:0] next_wStrbQ;
    logic [1:0] next_bresp, next_rresp;

    // Address and data are held separately so either may arrive first.
    assign awready = !awHeld;
    assign wready = !wHeld;
    assign arready = !rvalid;
    assign doWrite = awHeld && wHeld && !bvalid;
    assign regs.wrEn = doWrite;
    assign regs.wrAddr = awAddrQ;
    assign regs.wrData = wDataQ;
    assign regs.wrStrb = wStrbQ;
    assign regs.rdAddr = araddr;

    always_comb begin
        next_awHeld = awHeld;
        next_wHeld = wHeld;
        next_awAddrQ = awAddrQ;
        next_wDataQ = wDataQ;
        next_wStrbQ = wStrbQ;
        next_bvalid = bvalid;
        next_bresp = bresp;
        next_rvalid = rvalid;
        next_rdata = rdata;
        next_rresp = rresp;
        if (awvalid && !awHeld) begin
            next_awHeld = 1'b1;
            next_awAddrQ = awaddr;
        end
        if (wvalid && !wHeld) begin
            next_wHeld = 1'b1;
            next_wDataQ = wdata;
            next_wStrbQ = wstrb;
        end
        if (bvalid && bready) begin
            next_bvalid = 1'b0;
        end
        if (doWrite) begin
            next_awHeld = 1'b0;
            next_wHeld = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = regs.wrOk ? `EAC_RESP_OKAY : `EAC_RESP_SLVERR;
        end
        if (rvalid && rready) begin
            next_rvalid = 1'b0;
        end
        if (arvalid && !rvalid) begin
            next_rvalid = 1'b1;
            next_rdata = regs.rdOk ? regs.rdData : 32'h0;
            next_rresp = regs.rdOk ? `EAC_RESP_OKAY : `EAC_RESP_SLVERR;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            awHeld <= 1'b0;
            wHeld <= 1'b0;
            awAddrQ <= 8'h0;
            wDataQ <= 32'h0;
            wStrbQ <= 4'h0;
            bvalid <= 1'b0;
            bresp <= 2'h0;
            rvalid <= 1'b0;
            rdata <= 32'h0;
            rresp <= 2'h0;
        end else begin
            awHeld <= next_awHeld;
            wHeld <= next_wHeld;
            awAddrQ <= next_awAddrQ;
            wDataQ <= next_wDataQ;
            wStrbQ <= next_wStrbQ;
            bvalid <= next_bvalid;
            bresp <= next_bresp;
            rvalid <= next_rvalid;
            rdata <= next_rdata;
            rresp <= next_rresp;
        end
    end
endmodule : eac_axil_slave
`default_nettype wire

// ### testbench/eac_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module eac_mem_model (
    input wire logic clk,
    input wire logic slow,
    input wire logic [3:0] fastRegAddr,
    output logic [0:35] fastRegData,
    input wire logic indirectRequestFn,
    input wire logic memField02,
    input wire logic [13:35] virtualAddrReg,
    output logic memRespValid,
    output logic [0:35] memRespWord
);
    logic [0:35] idxReg [16];
    logic [0:35] memWord [256];
    logic pend = 1'b0;
    logic [2:0] waitCnt = 3'h0;
    logic [7:0] addr = 8'h00;
    initial memRespValid = 1'b0;
    initial memRespWord = 36'h0;
    // The index register file answers combinationally to the selector.
    assign fastRegData = idxReg[fastRegAddr];
    // After a response the word line is inverted so a stale value never looks valid.
    always @(posedge clk) begin
        memRespValid <= 1'b0;
        if (memRespValid) begin
            memRespWord <= ~memRespWord;
        end
        if (indirectRequestFn === 1'b1) begin
            pend <= 1'b1;
            waitCnt <= slow ? 3'h5 : 3'h0;
            addr <= virtualAddrReg[28:35];
        end else if (pend && waitCnt != 3'h0) begin
            waitCnt <= waitCnt - 3'h1;
        end else if (pend && memField02 === 1'b1) begin
            pend <= 1'b0;
            memRespValid <= 1'b1;
            memRespWord <= memWord[addr];
        end
    end
endmodule : eac_mem_model
`default_nettype wire

// ### testbench/test_effective_address_calc.sv
`timescale 1ns/1ps
`default_nettype none
module test_effective_address_calc;
    logic clk, rst_n, slow, instrLoad, instrReady, indirectRequestFn, memField02, memoryWait;
    logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb, fastRegAddr, destAccBase;
    logic [1:0] bresp, rresp;
    logic [0:35] instrWord, fastRegData, memRespWord, arithReg;
    logic memRespValid, fetchDispatch, blockTransferOp, dpFloatAdd, dpFloatSub;
    logic doubleIntMultiply;
    logic [13:35] virtualAddrReg;
    logic [2:0] destAccCount;
    int errors = 0;
    int comparisons = 0;
    int cycles = 0;
    int seed;
    logic [17:0] lastVa = 18'h0;
    logic [7:0] indExp = 8'h0;
    logic [4:0] vsect = 5'h15;
    logic [8:0] ops [8] = '{9'h0A9, 9'h048, 9'h049, 9'h04E, 9'h04A, 9'h04C, 9'h04F, 9'h0C8};
    logic [0:35] w;
    logic [17:0] e;

    eac_core dut (.*);
    eac_mem_model pm (.*);

    always #5 clk = ~clk;

    task automatic end_of_test;
        if (errors == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : end_of_test

    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            end_of_test();
        end
    end

    task automatic chkd(input logic [35:0] g, input logic [35:0] x);
        comparisons++;
        if (g !== x) begin
            errors++;
            $display("[ERR] %0t got %h exp %h", $time, g, x);
        end
    endtask : chkd

    task automatic chkb(input logic [31:0] g, input logic [31:0] x);
        comparisons++;
        if (g !== x) begin
            errors++;
            $display("[ERR] %0t got %h exp %h", $time, g, x);
        end
    endtask : chkb

    task automatic axiWr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic aw, wd, ta, tw;
        @(posedge clk);
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= d;
        wvalid <= 1'b1;
        bready <= 1'b1;
        aw = 1'b0;
        wd = 1'b0;
        while (!(aw && wd)) begin
            @(negedge clk);
            ta = !aw && awready === 1'b1;
            tw = !wd && wready === 1'b1;
            @(posedge clk);
            if (ta) begin
                awvalid <= 1'b0;
                aw = 1'b1;
            end
            if (tw) begin
                wvalid <= 1'b0;
                wd = 1'b1;
            end
        end
        do @(negedge clk); while (bvalid !== 1'b1);
        chkb({30'h0, bresp}, {30'h0, er});
        @(posedge clk);
        bready <= 1'b0;
    endtask : axiWr

    task automatic axiRd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(negedge clk); while (arready !== 1'b1);
        @(posedge clk);
        arvalid <= 1'b0;
        do @(negedge clk); while (rvalid !== 1'b1);
        chkb(rdata, ed);
        chkb({30'h0, rresp}, {30'h0, er});
        @(posedge clk);
        rready <= 1'b0;
    endtask : axiRd

    // Follows the indirect chain through the model's memory and records the last VA load.
    function automatic logic [17:0] calcEa(input logic [0:35] iw);
        logic [17:0] s;
        s = 18'h0;
        indExp = 8'h0;
        for (int d = 0; d < 4; d++) begin
            s = iw[18:35];
            if (iw[14:17] != 4'h0) begin
                s = s + pm.idxReg[iw[14:17]][18:35];
                lastVa = s;
            end
            if (iw[13] == 1'b0) break;
            lastVa = s;
            indExp = indExp + 8'h01;
            iw = pm.memWord[s[7:0]];
        end
        return s;
    endfunction : calcEa

    function automatic logic [10:0] calcDest(input logic [0:35] iw);
        logic [8:0] op;
        logic [2:0] n;
        op = iw[0:8];
        n = (op == 9'h04E) ? 3'h4 : (op >= 9'h048 && op <= 9'h04D) ? 3'h2 : 3'h0;
        return {op == 9'h0A9, op == 9'h048, op == 9'h049, op == 9'h04E, n, iw[9:12]};
    endfunction : calcDest

    task automatic runInstr(input logic [0:35] iw);
        logic ok;
        int n;
        e = calcEa(iw);
        @(posedge clk);
        instrWord <= iw;
        instrLoad <= 1'b1;
        ok = 1'b0;
        while (!ok) begin
            @(negedge clk);
            ok = instrReady === 1'b1;
            @(posedge clk);
        end
        instrLoad <= 1'b0;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (fetchDispatch !== 1'b1 && n < 300);
        chkd(fetchDispatch, 1'b1);
        if (iw[13] == 1'b0) chkd(n, iw[14:17] != 4'h0 ? 3 : 2);
        chkd(arithReg, {18'h0, e});
        chkd(virtualAddrReg, {vsect, lastVa});
        chkd({blockTransferOp, dpFloatAdd, dpFloatSub, doubleIntMultiply,
              destAccCount, destAccBase}, calcDest(iw));
        axiRd(8'h18, {24'h0, indExp}, 2'h0);
    endtask : runInstr

    // A request cycle never carries the wait-causing memory bit.
    always @(negedge clk) begin
        if (indirectRequestFn === 1'b1) chkd(memField02, 1'b0);
        if (memField02 === 1'b1) chkd(memoryWait, pm.pend);
    end

    initial begin
        seed = 13391;
        {clk, rst_n, slow, instrLoad, awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, araddr, wdata, wstrb, instrWord} = '0;
        wstrb = 4'hF;
        for (int i = 0; i < 16; i++) pm.idxReg[i] = 36'({$random(seed), $random(seed)});
        for (int k = 0; k < 256; k++) begin
            w = 36'({$random(seed), $random(seed)});
            if (k < 128) begin
                w[14:17] = 4'h0;
                w[28] = 1'b1;
            end else begin
                w[13] = 1'b0;
            end
            pm.memWord[k] = w;
        end
        pm.idxReg[1][18:35] = 18'h00002;
        pm.memWord[5][13] = 1'b1;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        axiRd(8'h00, 32'h1, 2'h0);
        axiRd(8'h04, 32'h0, 2'h0);
        axiWr(8'h1C, 32'h0, 2'h2);
        axiRd(8'h1C, 32'h0, 2'h2);
        axiWr(8'h08, 32'h1, 2'h2);
        axiWr(8'h10, {27'h0, vsect}, 2'h0);
        axiRd(8'h10, {27'h0, vsect}, 2'h0);
        for (int c = 0; c < 4; c++) begin
            w = {ops[c], 4'h3, c >= 2, 4'(c[0] ? c : 0), c[1] ? 18'h00005 : 18'h3FFFF};
            runInstr(w);
            axiRd(8'h08, {14'h0, e}, 2'h0);
            axiRd(8'h0C, {9'h0, vsect, lastVa}, 2'h0);
            axiRd(8'h14, {21'h0, calcDest(w)}, 2'h0);
        end
        for (int r = 0; r < 48; r++) begin
            slow = $random(seed);
            w = 36'({$random(seed), $random(seed)});
            w[0:8] = ops[r % 8];
            runInstr(w);
        end
        axiWr(8'h00, 32'h0, 2'h0);
        @(posedge clk);
        instrLoad <= 1'b1;
        repeat (3) @(posedge clk);
        @(negedge clk);
        chkd({instrReady, fetchDispatch}, 2'b00);
        @(posedge clk);
        instrLoad <= 1'b0;
        axiWr(8'h00, 32'h1, 2'h0);
        runInstr({ops[3], 4'h0, 1'b0, 4'h1, 18'h3FFFF});
        end_of_test();
    end
endmodule : test_effective_address_calc
`default_nettype wire
